/* File: src/wakeup_irq_pkg.sv */
package wakeup_irq_pkg;
  // number of wakeup inputs
  localparam int unsigned WAKE_COUNT = 8;
  // timer a counter width and its wrap points
  localparam int unsigned TMR_WIDTH = 8;
  localparam logic [7:0] TMR_MAX = 8'hFF;
  localparam logic [7:0] TMR_ZERO = 8'h00;
  // flag reset values
  localparam logic FLAG_RST = 1'h0;
  localparam logic [7:0] WAKE_FLAG_RST = 8'h00;
  // edge select encoding
  localparam logic EDGE_SEL_FALL = 1'h0;
  localparam logic EDGE_SEL_RISE = 1'h1;
  // synchronised input reset levels (pins idle high)
  localparam logic PIN_IDLE = 1'h1;
  localparam logic [7:0] WAKE_PIN_IDLE = 8'hFF;
  // write value that clears a flag
  localparam logic CLEAR_VAL = 1'h0;
endpackage : wakeup_irq_pkg

/* File: src/edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
// single edge detector for one synchronous input
module edge_detect
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic sig_i,
  input wire logic rise_sel_i,
  output logic edge_o
);
  logic prev_q; // previous sample of the input
  logic prev_d;

  // next previous-sample value
  always_comb
  begin
    prev_d = sig_i;
  end

  // register the previous sample, idle high after reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prev_q <= wakeup_irq_pkg::PIN_IDLE;
    end
    else
    begin
      prev_q <= prev_d;
    end
  end

  // rising or falling edge selected by rise_sel_i
  always_comb
  begin
    if (rise_sel_i)
    begin
      edge_o = sig_i & ~prev_q;
    end
    else
    begin
      edge_o = ~sig_i & prev_q;
    end
  end
endmodule : edge_detect
`default_nettype wire

/* File: src/wakeup_irq_flag_logic.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] edge select: clear falling, set rising
// [R2] timer a flag set on FF to 00
// [R3] timer a flag cleared by zero write
// [R4] timer a request needs enable set
// [R5] direct-transition request gated by enable
// [R6] direct-transition flag set on direct sleep
// [R7] direct-transition flag cleared by zero write
// [R8] wakeup flag set on enabled falling edge
// [R9] wakeup flag cleared by zero write
// [R10] wakeup flag ignores one writes
// [R11] timer flag register accepts only zeros
// [R12] transition flag register accepts only zeros
// [R13] request only when flag and enable set; the wakeup request has no enable, any set wakeup flag raises it
module wakeup_irq_flag_logic
#(
  parameter int unsigned WAKE_N = wakeup_irq_pkg::WAKE_COUNT
)
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // shared external interrupt and converter trigger pin
  input wire logic edge_irq_input_i,
  input wire logic edge_sel_rise_i,
  // timer a counter value and overflow enable
  input wire logic [7:0] timer_a_count_i,
  input wire logic timer_a_irq_en_i,
  // timer a flag write strobe and data
  input wire logic timer_a_flag_wr_i,
  input wire logic timer_a_flag_wdata_i,
  // low-power instruction and direct transition status
  input wire logic sleep_exec_i,
  input wire logic direct_transfer_control_i,
  input wire logic direct_transition_taken_i,
  input wire logic direct_transition_irq_en_i,
  input wire logic direct_transition_flag_wr_i,
  input wire logic direct_transition_flag_wdata_i,
  // wakeup pins, their function select and flag write
  input wire logic [WAKE_N-1:0] wakeup_input_n_i,
  input wire logic [WAKE_N-1:0] wakeup_pin_sel_i,
  input wire logic wakeup_flag_wr_i,
  input wire logic [WAKE_N-1:0] wakeup_flag_wdata_i,
  // outputs
  output logic edge_irq_event_o,
  output logic timer_a_request_flag_o,
  output logic timer_a_irq_o,
  output logic direct_transition_request_flag_o,
  output logic direct_transition_irq_o,
  output logic [WAKE_N-1:0] wakeup_request_flag_n_o,
  output logic wakeup_irq_o
);

  // clear decode: a write of zero to a flag that holds one
  function automatic logic zero_clear(input logic wr, input logic wd,
                                      input logic flag);
    zero_clear = wr & (wd == wakeup_irq_pkg::CLEAR_VAL) & flag;
  endfunction : zero_clear

  // edge seen on the shared pin this cycle
  logic edge_hit;
  // falling edges on the wakeup pins
  logic [WAKE_N-1:0] wake_fall;
  // timer a group: last sampled count, flag and request
  logic [wakeup_irq_pkg::TMR_WIDTH-1:0] tmr_prev_q;
  logic [wakeup_irq_pkg::TMR_WIDTH-1:0] tmr_prev_d;
  logic tmr_flag_q; // timer a flag
  logic tmr_flag_d;
  logic tmr_irq_q; // timer a request
  logic tmr_irq_d;
  logic tmr_wrap; // counter stepped from top to zero
  logic tmr_clr; // zero write hits a set timer flag
  // direct-transition group: flag and request
  logic dt_flag_q; // direct-transition flag
  logic dt_flag_d;
  logic dt_irq_q; // direct-transition request
  logic dt_irq_d;
  logic dt_set; // direct transition happened
  logic dt_clr; // zero write hits a set transition flag
  // wakeup group: one flag per pin, one shared request
  logic [WAKE_N-1:0] wk_flag_q;
  logic [WAKE_N-1:0] wk_flag_d;
  logic wk_irq_q;
  logic wk_irq_d;
  // shared pin event, registered for one cycle
  logic edge_evt_q;
  logic edge_evt_d;

  // shared pin edge detector with selectable polarity
  edge_detect u_edge_irq
  (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .sig_i(edge_irq_input_i),
    .rise_sel_i(edge_sel_rise_i), // R1
    .edge_o(edge_hit)
  );

  // falling edge detectors, one per wakeup pin
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_N; gi++)
    begin : g_wake
      edge_detect u_wake
      (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .sig_i(wakeup_input_n_i[gi]),
        .rise_sel_i(wakeup_irq_pkg::EDGE_SEL_FALL),
        .edge_o(wake_fall[gi])
      );
    end
  endgenerate

  // timer a: wrap detect, flag update and gated request
  always_comb
  begin
    tmr_prev_d = timer_a_count_i;
    // overflow is seen as the top value followed by zero
    tmr_wrap = (tmr_prev_q == wakeup_irq_pkg::TMR_MAX) &&
               (timer_a_count_i == wakeup_irq_pkg::TMR_ZERO); // R2
    // only a zero write clears; a one write leaves the flag alone
    tmr_clr = zero_clear(timer_a_flag_wr_i, timer_a_flag_wdata_i,
                         tmr_flag_q); // R3 R11
    tmr_flag_d = tmr_flag_q;
    if (tmr_clr)
    begin
      // software clear
      tmr_flag_d = wakeup_irq_pkg::FLAG_RST; // R3
    end
    if (tmr_wrap)
    begin
      // a wrap in the clearing cycle is not lost
      tmr_flag_d = 1'h1; // R2
    end
    // request follows the next flag so both change on one edge
    tmr_irq_d = tmr_flag_d & timer_a_irq_en_i; // R4 R13
  end

  // timer a registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tmr_prev_q <= wakeup_irq_pkg::TMR_ZERO;
      tmr_flag_q <= wakeup_irq_pkg::FLAG_RST;
      tmr_irq_q <= wakeup_irq_pkg::FLAG_RST;
    end
    else
    begin
      tmr_prev_q <= tmr_prev_d;
      tmr_flag_q <= tmr_flag_d;
      tmr_irq_q <= tmr_irq_d;
    end
  end

  // direct transition: flag set by a direct sleep exit, zero-write clear
  always_comb
  begin
    // the low-power instruction must run with direct transfer on and
    // the transition must actually be made
    dt_set = sleep_exec_i & direct_transfer_control_i &
             direct_transition_taken_i; // R6
    dt_clr = zero_clear(direct_transition_flag_wr_i,
                        direct_transition_flag_wdata_i, dt_flag_q); // R7 R12
    dt_flag_d = dt_flag_q;
    if (dt_clr)
    begin
      // software clear
      dt_flag_d = wakeup_irq_pkg::FLAG_RST; // R7
    end
    if (dt_set)
    begin
      // set wins over a clear in the same cycle
      dt_flag_d = 1'h1; // R6
    end
    // request blocked while the enable is low
    dt_irq_d = dt_flag_d & direct_transition_irq_en_i; // R5 R13
  end

  // direct transition registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dt_flag_q <= wakeup_irq_pkg::FLAG_RST;
      dt_irq_q <= wakeup_irq_pkg::FLAG_RST;
    end
    else
    begin
      dt_flag_q <= dt_flag_d;
      dt_irq_q <= dt_irq_d;
    end
  end

  // wakeup flags: set on a selected falling edge, cleared per bit
  always_comb
  begin
    for (int i = 0; i < WAKE_N; i++)
    begin
      // a one in the write data keeps the flag
      wk_flag_d[i] = wk_flag_q[i]; // R10
      if (zero_clear(wakeup_flag_wr_i, wakeup_flag_wdata_i[i],
                     wk_flag_q[i]))
      begin
        // a zero bit of the write clears this flag only
        wk_flag_d[i] = wakeup_irq_pkg::FLAG_RST; // R9
      end
      if (wake_fall[i] & wakeup_pin_sel_i[i])
      begin
        // a falling edge in the clearing cycle wins
        wk_flag_d[i] = 1'h1; // R8
      end
    end
    // any pending wakeup flag raises the shared request
    wk_irq_d = |wk_flag_d; // R13
  end

  // wakeup registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wk_flag_q <= {WAKE_N{wakeup_irq_pkg::FLAG_RST}};
      wk_irq_q <= wakeup_irq_pkg::FLAG_RST;
    end
    else
    begin
      wk_flag_q <= wk_flag_d;
      wk_irq_q <= wk_irq_d;
    end
  end

  // shared pin edge event, held for one cycle
  always_comb
  begin
    edge_evt_d = edge_hit; // R1
  end

  // shared pin event register
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      edge_evt_q <= wakeup_irq_pkg::FLAG_RST;
    end
    else
    begin
      edge_evt_q <= edge_evt_d;
    end
  end

  // outputs straight from flip-flops
  assign edge_irq_event_o = edge_evt_q;
  assign timer_a_request_flag_o = tmr_flag_q;
  assign timer_a_irq_o = tmr_irq_q;
  assign direct_transition_request_flag_o = dt_flag_q;
  assign direct_transition_irq_o = dt_irq_q;
  assign wakeup_request_flag_n_o = wk_flag_q;
  assign wakeup_irq_o = wk_irq_q;

endmodule : wakeup_irq_flag_logic
`default_nettype wire

/* File: verif/wakeup_irq_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the flag block ports
module wakeup_irq_asserts
#(
  parameter int unsigned WAKE_N = 8
)
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic edge_irq_input_i,
  input wire logic edge_sel_rise_i,
  input wire logic [7:0] timer_a_count_i,
  input wire logic timer_a_irq_en_i,
  input wire logic timer_a_flag_wr_i,
  input wire logic timer_a_flag_wdata_i,
  input wire logic sleep_exec_i,
  input wire logic direct_transfer_control_i,
  input wire logic direct_transition_taken_i,
  input wire logic direct_transition_irq_en_i,
  input wire logic wakeup_flag_wr_i,
  input wire logic edge_irq_event_o,
  input wire logic timer_a_request_flag_o,
  input wire logic timer_a_irq_o,
  input wire logic direct_transition_request_flag_o,
  input wire logic direct_transition_irq_o,
  input wire logic [WAKE_N-1:0] wakeup_request_flag_n_o,
  input wire logic wakeup_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // counter steps from its top value to zero
  sequence timer_wrap;
    timer_a_count_i == 8'hFF ##1 timer_a_count_i == 8'h00;
  endsequence
  // shared pin goes low with falling edge selected
  sequence pin_fall;
    edge_irq_input_i ##1 !edge_irq_input_i && !edge_sel_rise_i;
  endsequence
  chk_timer_wrap: assert property (
    timer_wrap |=> timer_a_request_flag_o) else $error("no flag on wrap");
  chk_timer_clear: assert property (
    timer_a_request_flag_o && timer_a_flag_wr_i && !timer_a_flag_wdata_i
    && !($past(timer_a_count_i) == 8'hFF && timer_a_count_i == 8'h00)
    |=> !timer_a_request_flag_o) else $error("timer flag not cleared");
  chk_timer_gate: assert property (
    timer_a_irq_o == (timer_a_request_flag_o && $past(timer_a_irq_en_i)))
    else $error("timer request wrong");
  chk_direct_set: assert property (
    sleep_exec_i && direct_transfer_control_i && direct_transition_taken_i
    |=> direct_transition_request_flag_o) else $error("no direct flag");
  chk_direct_gate: assert property (
    direct_transition_irq_o == (direct_transition_request_flag_o
    && $past(direct_transition_irq_en_i))) else $error("direct request");
  chk_wake_req: assert property (
    wakeup_irq_o == |wakeup_request_flag_n_o) else $error("wake request");
  chk_edge_fall: assert property (
    pin_fall |=> edge_irq_event_o) else $error("falling edge missed");
  chk_wake_keep: assert property (
    !wakeup_flag_wr_i |=> (wakeup_request_flag_n_o &
    $past(wakeup_request_flag_n_o)) == $past(wakeup_request_flag_n_o))
    else $error("wake flag lost");
endmodule : wakeup_irq_asserts
bind wakeup_irq_flag_logic wakeup_irq_asserts #(.WAKE_N(WAKE_N)) u_chk (.*);
`default_nettype wire

/* File: verif/test_wakeup_irq_flag_logic.sv */
`timescale 1ns/1ps
`default_nettype none
module test_wakeup_irq_flag_logic;
  // block ports, connected by name
  logic clk_sys_i, arst_n_i, edge_irq_input_i, edge_sel_rise_i;
  logic timer_a_irq_en_i, timer_a_flag_wr_i, timer_a_flag_wdata_i;
  logic sleep_exec_i, direct_transfer_control_i, direct_transition_taken_i;
  logic direct_transition_irq_en_i, direct_transition_flag_wr_i;
  logic direct_transition_flag_wdata_i, wakeup_flag_wr_i, wakeup_irq_o;
  logic [7:0] timer_a_count_i, wakeup_input_n_i, wakeup_pin_sel_i;
  logic [7:0] wakeup_flag_wdata_i, wakeup_request_flag_n_o;
  logic edge_irq_event_o, timer_a_request_flag_o, timer_a_irq_o;
  logic direct_transition_request_flag_o, direct_transition_irq_o;
  logic [11:0] s; // packed single-bit stimulus
  logic [13:0] exp_q[$]; // expected outputs, oldest first
  logic pin_q, tf_q, df_q; // reference state
  logic [7:0] cnt_q, wp_q, wf_q;
  int mismatches, checked, seed, pend;
  assign {edge_irq_input_i, edge_sel_rise_i, timer_a_irq_en_i,
    timer_a_flag_wr_i, timer_a_flag_wdata_i, sleep_exec_i,
    direct_transfer_control_i, direct_transition_taken_i,
    direct_transition_irq_en_i, direct_transition_flag_wr_i,
    direct_transition_flag_wdata_i, wakeup_flag_wr_i} = s;
  wakeup_irq_flag_logic u_wakeup_irq_flag_logic (.*);
  // free running clock
  initial
  begin
    clk_sys_i = 1'h0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // report a mismatch and count each compare
  task automatic cmp(logic [13:0] x, logic [13:0] g);
    checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value outputs exp %h got %h", x, g);
    end
  endtask : cmp
  // print counts and verdict, then stop
  task automatic test_done();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // drive one random cycle and note the expected outputs
  task automatic step();
    logic [31:0] r;
    logic [13:0] x;
    @(posedge clk_sys_i);
    #1;
    r = $random(seed);
    s = r[11:0];
    timer_a_count_i = r[12] ? {8{r[13]}} : r[21:14];
    r = $random(seed);
    {wakeup_input_n_i, wakeup_pin_sel_i, wakeup_flag_wdata_i} = r[23:0];
    x[13] = s[10] ? !pin_q && s[11] : pin_q && !s[11];
    tf_q = (cnt_q == 8'hFF && timer_a_count_i == 8'h00)
      || (tf_q && !(s[8] && !s[7]));
    df_q = (s[6] && s[5] && s[4]) || (df_q && !(s[2] && !s[1]));
    wf_q = (wp_q & ~wakeup_input_n_i & wakeup_pin_sel_i)
      | (wf_q & ~(s[0] ? ~wakeup_flag_wdata_i : 8'h00));
    x[12:0] = {tf_q, tf_q && s[9], df_q, df_q && s[3], wf_q, |wf_q};
    pin_q = s[11];
    cnt_q = timer_a_count_i;
    wp_q = wakeup_input_n_i;
    exp_q.push_back(x);
  endtask : step
  // compare outputs with the oldest note after each edge
  always @(posedge clk_sys_i)
  begin
    pend = exp_q.size(); // only notes made before this edge are due now
    #2;
    if (pend > 0)
      cmp(exp_q.pop_front(), {edge_irq_event_o, timer_a_request_flag_o,
        timer_a_irq_o, direct_transition_request_flag_o,
        direct_transition_irq_o, wakeup_request_flag_n_o,
        wakeup_irq_o});
  end
  // reset, then random traffic
  initial
  begin
    seed = 32'hF401;
    // pins idle high, counter at zero, no strobes while in reset
    {arst_n_i, s, timer_a_count_i, wakeup_pin_sel_i} = 29'h08000000;
    {wakeup_input_n_i, wakeup_flag_wdata_i} = 16'hFF00;
    {pin_q, tf_q, df_q, cnt_q, wp_q, wf_q} = 27'h400FF00;
    repeat (16) @(posedge clk_sys_i);
    #1 arst_n_i = 1'h1;
    repeat (600) step();
    repeat (3) @(posedge clk_sys_i);
    test_done();
  end
  // cut a hang short
  initial
  begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule : test_wakeup_irq_flag_logic
`default_nettype wire
